// ---- verilog/adc_frame_ctrl.sv ----
// Serial frame and power-mode control of a 12-bit sampling converter.
// Assumes frame select and serial clock arrive asynchronously from the host,
// and the conversion core answers each sample request over code_i.
`timescale 1ns/1ps
`include "adc_frame_defines.svh"

// Operation
// - Result is straight binary, step supply/4096
// - Frame-select fall: normal mode, start conversion
// - Rise at falls 2..10: abort, float, shutdown
// - Rise before fall 2 keeps mode
// - Rise at falls 11..15: abort, float, stay normal
// - Sixteen clocks per word, then output floats
// - Shutdown holds until select falls again
// - Shutdown turns analog circuitry off
// - First conversion after shutdown exit is invalid
// - Waking, rise before fall 10 returns shutdown
// - Three zeros then twelve bits, MSB first
// - Select fall drives output, sample, hold
// - Track again on 13th rise; host waits 350ns
// - Float after fall 16 or select rise
module adc_frame_ctrl
	import adc_frame_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Host pins
	input wire logic frame_sel_n_i,
	input wire logic serial_clk_i,
	output logic serial_result_out_o,
	output logic serial_result_oe_o,
	// Conversion core
	input wire logic [11:0] code_i,
	input wire logic code_valid_i,
	output logic code_ready_o,
	output logic sample_o,
	output logic track_o,
	output logic analog_on_o,
	output logic conv_valid_o
);

	word_buf_if bus ();

	logic cs_s1, cs_s2, cs_s3;
	logic sck_s1, sck_s2, sck_s3;
	logic cs_fall, cs_rise, sck_fall, sck_rise;
	pwr_mode_t mode, next_mode;
	logic active, next_active;
	logic warming, next_warming;
	logic [`CNT_W-1:0] cnt, next_cnt, cnt_inc;
	logic [`CNT_W-1:0] rise_cnt, next_rise_cnt, rise_inc;
	code_t shift, next_shift;
	logic next_sdo, next_oe, next_track, next_sample, next_valid, pop;

	function automatic logic in_range(input logic [`CNT_W-1:0] v,
		input logic [`CNT_W-1:0] lo, input logic [`CNT_W-1:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edges are taken from the second and third stages
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			sck_s1 <= 1'b1;
			sck_s2 <= 1'b1;
			sck_s3 <= 1'b1;
		end
		else
		begin
			cs_s1 <= frame_sel_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			sck_s1 <= serial_clk_i;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
		end
	end

	// only a high-to-low transition starts a frame
	assign cs_fall = cs_s3 && !cs_s2;
	assign cs_rise = !cs_s3 && cs_s2;
	assign sck_fall = sck_s3 && !sck_s2;
	assign sck_rise = !sck_s3 && sck_s2;
	assign cnt_inc = cnt + `CNT_ONE;
	assign rise_inc = rise_cnt + `CNT_ONE;

	////////////////////////////////////////////////////////////////////////
	// Result buffer: the core may run ahead by two words without loss
	assign bus.in_data = code_i;
	assign bus.in_valid = code_valid_i;
	assign bus.out_ready = pop;
	assign code_ready_o = bus.in_ready;

	result_buf u_buf
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.bus(bus)
	);

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_comb
	begin
		next_mode = mode;
		next_active = active;
		next_warming = warming;
		next_cnt = cnt;
		next_rise_cnt = rise_cnt;
		next_shift = shift;
		next_sdo = serial_result_out_o;
		next_oe = serial_result_oe_o;
		next_track = track_o;
		next_sample = 1'b0;
		next_valid = conv_valid_o;
		pop = 1'b0;
		if (cs_fall)
		begin
			next_mode = MODE_NORMAL;
			next_active = 1'b1;
			next_cnt = `CNT_ZERO;
			next_rise_cnt = `CNT_ZERO;
			next_oe = 1'b1;
			next_sdo = 1'b0;
			next_track = 1'b0;
			next_sample = 1'b1;
			next_warming = (mode == MODE_SHUTDOWN) || warming;
			next_valid = !next_warming;
		end
		else if (active && cs_rise)
		begin
			next_active = 1'b0;
			next_oe = 1'b0;
			next_sdo = 1'b0;
			next_track = 1'b1;
			if (warming && (cnt < `CNT_SHDN_LAST))
			begin
				next_mode = MODE_SHUTDOWN;
			end
			else if (in_range(cnt, `CNT_SHDN_FIRST, `CNT_SHDN_LAST))
			begin
				next_mode = MODE_SHUTDOWN;
			end
			// otherwise mode is kept, word truncated
		end
		else if (active && sck_fall)
		begin
			next_cnt = cnt_inc;
			if (cnt_inc == `CNT_DATA_FIRST)
			begin
				pop = bus.out_valid;
				next_shift = bus.out_valid ? bus.out_data : `CODE_ZERO;
				next_valid = conv_valid_o && bus.out_valid;
				next_sdo = next_shift[`RES_BITS-1];
				next_shift = {next_shift[`RES_BITS-2:0], 1'b0};
			end
			else if (in_range(cnt_inc, `CNT_DATA_FIRST, `CNT_DATA_LAST))
			begin
				next_sdo = shift[`RES_BITS-1];
				next_shift = {shift[`RES_BITS-2:0], 1'b0};
			end
			else if (cnt_inc == `CNT_WORD)
			begin
				next_oe = 1'b0;
				next_active = 1'b0;
				next_warming = 1'b0;
				next_sdo = 1'b0;
			end
			else
			begin
				next_sdo = 1'b0;
			end
		end
		else if (active && sck_rise)
		begin
			next_rise_cnt = rise_inc;
			// back to track on 13th rise
			if (rise_inc == `CNT_TRACK_RISE)
			begin
				next_track = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mode <= MODE_SHUTDOWN;
			active <= 1'b0;
			warming <= 1'b1;
			cnt <= `CNT_ZERO;
			rise_cnt <= `CNT_ZERO;
			shift <= `CODE_ZERO;
			serial_result_out_o <= 1'b0;
			serial_result_oe_o <= 1'b0;
			track_o <= 1'b1;
			sample_o <= 1'b0;
			conv_valid_o <= 1'b0;
			analog_on_o <= 1'b0;
		end
		else
		begin
			mode <= next_mode;
			active <= next_active;
			warming <= next_warming;
			cnt <= next_cnt;
			rise_cnt <= next_rise_cnt;
			shift <= next_shift;
			serial_result_out_o <= next_sdo;
			serial_result_oe_o <= next_oe;
			track_o <= next_track;
			sample_o <= next_sample;
			conv_valid_o <= next_valid;
			analog_on_o <= (next_mode == MODE_NORMAL);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_fall_normal;
		cs_fall |=> (mode == MODE_NORMAL) && serial_result_oe_o && !serial_result_out_o;
	endproperty
	a_fall_normal: assert property (p_fall_normal) else $error("frame start not normal");

	property p_fall_hold;
		cs_fall |=> !track_o && sample_o ##1 !sample_o;
	endproperty
	a_fall_hold: assert property (p_fall_hold) else $error("no sample on frame start");

	property p_shdn_window;
		active && cs_rise && in_range(cnt, `CNT_SHDN_FIRST, `CNT_SHDN_LAST)
			|=> (mode == MODE_SHUTDOWN) && !serial_result_oe_o && !analog_on_o;
	endproperty
	a_shdn_window: assert property (p_shdn_window) else $error("no shutdown on rise");

	property p_early_keep;
		active && cs_rise && (cnt < `CNT_SHDN_FIRST) && !warming |=> mode == $past(mode);
	endproperty
	a_early_keep: assert property (p_early_keep) else $error("early rise changed mode");

	property p_late_abort;
		active && cs_rise && (cnt > `CNT_SHDN_LAST) && (cnt < `CNT_WORD)
			|=> (mode == MODE_NORMAL) && !serial_result_oe_o;
	endproperty
	a_late_abort: assert property (p_late_abort) else $error("late rise wrong mode");

	property p_word_end;
		active && sck_fall && (cnt == `CNT_WORD - `CNT_ONE) && !cs_rise
			|=> !serial_result_oe_o && !active;
	endproperty
	a_word_end: assert property (p_word_end) else $error("output not floated at 16");

	property p_lead_zero;
		active && sck_fall && (cnt < `CNT_SHDN_FIRST) && !cs_rise
			|=> serial_result_oe_o && !serial_result_out_o;
	endproperty
	a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");

	property p_track;
		active && sck_rise && (rise_cnt == `CNT_TRACK_RISE - `CNT_ONE) && !cs_rise |=> track_o;
	endproperty
	a_track: assert property (p_track) else $error("no track on 13th rise");

	property p_wake_abort;
		active && cs_rise && warming && (cnt < `CNT_SHDN_LAST) |=> mode == MODE_SHUTDOWN;
	endproperty
	a_wake_abort: assert property (p_wake_abort) else $error("wake abort kept normal");

	property p_dummy;
		cs_fall && (mode == MODE_SHUTDOWN) |=> !conv_valid_o;
	endproperty
	a_dummy: assert property (p_dummy) else $error("wake frame marked valid");

	property p_stay_shdn;
		(mode == MODE_SHUTDOWN) && !cs_fall |=> (mode == MODE_SHUTDOWN) && !analog_on_o;
	endproperty
	a_stay_shdn: assert property (p_stay_shdn) else $error("left shutdown without fall");

	c_full_word: cover property (active && sck_fall && (cnt == `CNT_WORD - `CNT_ONE));
	c_enter_shdn: cover property (active && cs_rise && (cnt == `CNT_SHDN_FIRST));
	c_truncate: cover property (active && cs_rise && (cnt == `CNT_TRUNC));
	c_buf_full: cover property (!code_ready_o);

endmodule

// ---- verilog/adc_frame_defines.svh ----
// Constants of the serial conversion frame: falling- and rising-edge counts and word layout.
// Assumes counts start from zero at each frame-select fall.
`ifndef ADC_FRAME_DEFINES_SVH
`define ADC_FRAME_DEFINES_SVH

`define RES_BITS 12
`define CNT_W 5
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_SHDN_FIRST 5'h02
`define CNT_SHDN_LAST 5'h0A
`define CNT_DATA_FIRST 5'h03
`define CNT_DATA_LAST 5'h0E
`define CNT_WORD 5'h10
`define CNT_TRACK_RISE 5'h0D
`define CNT_TRUNC 5'h0C
`define CODE_ZERO 12'h000
`define BUF_DEPTH 2

`endif

// ---- verilog/adc_frame_pkg.sv ----
// Types shared by the frame controller and its result buffer.
// Assumes the defines header is compiled alongside.
package adc_frame_pkg;
	typedef enum logic {MODE_NORMAL, MODE_SHUTDOWN} pwr_mode_t;
	typedef logic [11:0] code_t;
endpackage

// ---- verilog/word_buf_if.sv ----
// Valid/ready carrier between the frame controller and its result buffer.
// Assumes both ends run on the single system clock.
`timescale 1ns/1ps
interface word_buf_if;
	logic [11:0] in_data;
	logic in_valid;
	logic in_ready;
	logic [11:0] out_data;
	logic out_valid;
	logic out_ready;
	modport store
	(
		input in_data,
		input in_valid,
		output in_ready,
		output out_data,
		output out_valid,
		input out_ready
	);
	modport user
	(
		output in_data,
		output in_valid,
		input in_ready,
		input out_data,
		input out_valid,
		output out_ready
	);
endinterface

// ---- verilog/result_buf.sv ----
// Two-entry result buffer with valid and ready on both sides.
// Assumes the producer holds data while in_valid is high and in_ready low.
`timescale 1ns/1ps
`include "adc_frame_defines.svh"
module result_buf
	import adc_frame_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Buffer ports
	word_buf_if.store bus
);

	code_t mem [`BUF_DEPTH];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] fill;
	logic full;
	logic next_wr_ptr;
	logic next_rd_ptr;
	logic [1:0] next_fill;
	logic push;
	logic pop;

	////////////////////////////////////////////////////////////////////////
	// Ready comes from a registered full flag so the top output is a flop
	assign push = bus.in_valid && !full;
	assign pop = bus.out_ready && (fill != 2'h0);
	assign bus.in_ready = !full;
	assign bus.out_valid = (fill != 2'h0);
	assign bus.out_data = mem[rd_ptr];

	always_comb
	begin
		next_wr_ptr = wr_ptr ^ push;
		next_rd_ptr = rd_ptr ^ pop;
		next_fill = fill;
		if (push && !pop)
		begin
			next_fill = fill + 2'h1;
		end
		else if (pop && !push)
		begin
			next_fill = fill - 2'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			fill <= 2'h0;
			full <= 1'b0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
			full <= (next_fill == 2'h2);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem[wr_ptr] <= bus.in_data;
		end
	end

endmodule

// ---- sim/host_port.sv ----
// Host serial port model: frame select and serial clock master, data capture.
// Assumes one caller at a time and a system clock fast against the serial clock.
`timescale 1ns/1ps
module host_port
(
	// Clock
	input wire logic clk_i,
	// Device pins and probes
	input wire logic serial_result_out_i,
	input wire logic oe_i,
	input wire logic track_i,
	output logic frame_sel_n_o,
	output logic sclk_o
);
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		frame_sel_n_o = 1'b1;
		sclk_o = 1'b1;
	end

	// Five system clocks per level keeps each serial level above the sync delay
	task automatic half();
		repeat (5) @(posedge clk_i);
		#1;
	endtask

	task automatic run_frame(input int n, output logic [15:0] w, output logic [15:0] trk,
		output logic oe_b);
		w = 'x;
		trk = 'x;
		@(posedge clk_i);
		#1;
		frame_sel_n_o = 1'b0;
		half();
		for (int k = 1; k <= n; k++)
		begin
			w[16-k] = oe_i ? serial_result_out_i : 1'bx;
			trk[16-k] = track_i;
			sclk_o = 1'b0;
			half();
			sclk_o = 1'b1;
			half();
		end
		oe_b = oe_i;
		// select raised after the chosen fall
		frame_sel_n_o = 1'b1;
		// idle gap gives a 20-clock frame, clock held high
		repeat (34) @(posedge clk_i);
	endtask
endmodule

// ---- sim/adc_frame_ctrl_bench.sv ----
// Self-checking bench of the frame controller against a queue model.
// Assumes host_port plays the host and the bench plays the conversion core.
`timescale 1ns/1ps
module adc_frame_ctrl_bench;
	import adc_frame_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic frame_sel_n_i;
	logic serial_clk_i;
	logic serial_result_out_o;
	logic serial_result_oe_o;
	logic [11:0] code_i;
	logic code_valid_i;
	logic code_ready_o;
	logic track_o;
	logic sample_o;
	logic analog_on_o;
	logic conv_valid_o;
	int n_fail = 0;
	int compares = 0;
	int cycles = 0;
	int n_sample = 0;
	int n;
	code_t q[$];
	code_t c;
	pwr_mode_t mode;
	bit wake;
	bit waking;
	bit popped;
	logic [15:0] w;
	logic [15:0] trk;
	logic oe_b;
	// Last two frames run without refill, so the buffer drains empty
	// A wake-up frame cut after fall 12 stays normal but keeps the next frame a dummy
	int frames[13] = '{16, 16, 16, 12, 1, 5, 1, 6, 12, 16, 16, 16, 16};

	adc_frame_ctrl adc_frame_ctrl_i
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.frame_sel_n_i(frame_sel_n_i),
		.serial_clk_i(serial_clk_i),
		.serial_result_out_o(serial_result_out_o),
		.serial_result_oe_o(serial_result_oe_o),
		.code_i(code_i),
		.code_valid_i(code_valid_i),
		.code_ready_o(code_ready_o),
		.sample_o(sample_o),
		.track_o(track_o),
		.analog_on_o(analog_on_o),
		.conv_valid_o(conv_valid_o)
	);

	host_port host_port_i
	(
		.clk_i(clk_i),
		.serial_result_out_i(serial_result_out_o),
		.oe_i(serial_result_oe_o),
		.track_i(track_o),
		.frame_sel_n_o(frame_sel_n_i),
		.sclk_o(serial_clk_i)
	);

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// Sample pulse stands one cycle, so the falling clock sees it once
	always @(negedge clk_i)
	begin
		if (sample_o === 1'b1)
			n_sample <= n_sample + 1;
	end

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic push(input code_t d);
		@(posedge clk_i);
		#1;
		code_valid_i = 1'b1;
		code_i = d;
		while (code_ready_o !== 1'b1)
		begin
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		#1;
		code_valid_i = 1'b0;
		q.push_back(d);
	endtask

	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Cuts a hang short; the whole run needs some 2000 cycles
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			n_fail++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h82591C63));
		rst_n_i = 1'b0;
		code_i = 12'h000;
		code_valid_i = 1'b0;
		mode = MODE_SHUTDOWN;
		wake = 1'b1;
		repeat (10) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		chk(serial_result_oe_o, 1'b0);
		chk(analog_on_o, 1'b0);
		chk(track_o, 1'b1);
		chk(code_ready_o, 1'b1);
		push(code_t'($urandom));
		push(code_t'($urandom));
		@(posedge clk_i);
		#1;
		chk(code_ready_o, 1'b0);
		foreach (frames[f])
		begin
			if (f < 11 && q.size() < 2)
				push(code_t'($urandom));
			n = frames[f];
			if (mode == MODE_SHUTDOWN)
				wake = 1'b1;
			waking = wake;
			mode = MODE_NORMAL;
			popped = (n >= 3) && (q.size() > 0);
			c = popped ? q.pop_front() : 12'h000;
			host_port_i.run_frame(n, w, trk, oe_b);
			chk(oe_b, n < 16);
			chk(serial_result_oe_o, 1'b0);
			if (n == 16)
			begin
				chk(conv_valid_o, !waking && popped);
				chk(trk, 16'h0007);
				if (!waking)
					chk(w, {3'b000, c, 1'b0});
				wake = 1'b0;
			end
			else if (n >= 2 && n <= 10)
				mode = MODE_SHUTDOWN;
			else if (n < 2 && waking)
				mode = MODE_SHUTDOWN;
			chk(analog_on_o, mode == MODE_NORMAL);
		end
		chk(16'(n_sample), 16'($size(frames)));
		final_report();
	end
endmodule
